/* File: core/wdt_params.svh */
// Constants for the windowed countdown watchdog
// How it works
// - The count field steps down by one every 49,152 machine cycles.
// - The six low count bits written by software set the timeout in 64 steps.
// - With the watchdog active, stepping from 40h to 3Fh starts a system reset.
// - On expiry the reset pin is driven low for a pulse of typically 500 ns.
// - After a presetn reset the watchdog is disabled with the activation bit clear; its own reset pulse leaves the bit set.
// - Once set, the activation bit cannot be cleared by software, only by reset.
// - A write with activation set and count bit 6 clear causes an immediate reset.
// - In halt the watchdog neither counts nor resets until interrupt or reset.
// - After an interrupt wake-up counting resumes only after 4096 CPU clocks.
// - Control bit 7 is the activation bit, bits 6 to 0 the readable live count.
// - The control register resets to 7Fh.
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define WDT_CTRL_ADDR     12'h00C
`define WDT_CTRL_RESET    8'h7F
`define WDT_ACT_BIT       7
`define WDT_MSB_BIT       6
`define WDT_CNT_EXPIRE    7'h40

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define WDT_CLK_MHZ       50
`define WDT_STEP_CYCLES   49152
`define WDT_PULSE_NS      500
`define WDT_PULSE_CYCLES  ((`WDT_PULSE_NS * `WDT_CLK_MHZ) / 1000)
`define WDT_WAKE_CYCLES   4096

`endif

/* File: core/wdt_pkg.sv */
// Types shared by the watchdog modules
package wdt_pkg;
    typedef enum logic [1:0] {
        WDT_RUN  = 2'b00,
        WDT_HALT = 2'b01,
        WDT_WAKE = 2'b10
    } wdt_mode_t;
endpackage

/* File: core/wdt_tick_if.sv */
// Prescaler control and tick between watchdog modules
`timescale 1ns/10ps
interface wdt_tick_if;
    logic restart;
    logic run;
    logic tick;
    modport ctrl (output restart, output run, input tick);
    modport div  (input restart, input run, output tick);
endinterface

/* File: core/wdt_prescaler.sv */
// Machine-cycle prescaler giving one tick per count step
`timescale 1ns/10ps
`include "wdt_params.svh"
module wdt_prescaler (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Tick channel
    wdt_tick_if.div   tk
);
    localparam logic [15:0] LAST = 16'(`WDT_STEP_CYCLES - 1);
    logic [15:0] cnt_reg;

    // Divider; freezes while not running so halt keeps the phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 16'h0000;
        end else if (tk.restart) begin
            cnt_reg <= 16'h0000;
        end else if (tk.run) begin
            cnt_reg <= (cnt_reg == LAST) ? 16'h0000 : cnt_reg + 16'h0001;
        end
    end

    // Tick marks the wrap edge itself, so no step can land after run drops for halt
    assign tk.tick = tk.run && !tk.restart && (cnt_reg == LAST);
endmodule

/* File: core/wdt_top.sv */
// Windowed countdown watchdog with APB control register
`timescale 1ns/10ps
`include "wdt_params.svh"
module wdt_top (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Power mode
    input  wire logic        halt_req,
    input  wire logic        ext_wake,
    // Reset request out
    output logic             reset_n_out
);
    // ------------------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------------------
    // Header constants, sized to the registers they meet
    localparam logic [7:0]  PULSE    = 8'(`WDT_PULSE_CYCLES);
    // Wake delay counts from zero, so its last value is one below this
    localparam logic [12:0] WAKE     = 13'(`WDT_WAKE_CYCLES);
    localparam logic [7:0]  CTRL_RST = `WDT_CTRL_RESET;
    localparam logic [6:0]  CNT_TRIP = `WDT_CNT_EXPIRE;
    localparam logic [11:0] CTRL_ADR = `WDT_CTRL_ADDR;

    // ------------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------------
    // True when an address selects the control register
    function automatic logic is_ctrl(input logic [11:0] addr);
        return addr == CTRL_ADR;
    endfunction

    // True when a written byte leaves the count msb clear while activated
    function automatic logic asks_reset(input logic [7:0] wbyte, input logic active);
        return (wbyte[`WDT_ACT_BIT] || active) && !wbyte[`WDT_MSB_BIT];
    endfunction

    // Read word: upper bits zero, activation above the live count
    function automatic logic [31:0] ctrl_word(input logic active, input logic [6:0] cnt);
        return {24'h000000, active, cnt};
    endfunction

    wdt_tick_if tk ();

    // Register state
    logic                 act_reg;
    logic [6:0]           count_reg;
    logic [7:0]           pulse_reg;
    logic [12:0]          wake_reg;
    wdt_pkg::wdt_mode_t   mode_reg;

    // Decode and event strobes
    logic                 setup;
    logic                 wr_ctrl;
    logic                 hit;
    logic                 step;
    logic                 natural_trip;
    logic                 forced_trip;
    logic                 expire;
    logic                 wake_done;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    // Setup cycle of a transfer; the slave answers on the next edge
    assign setup   = psel && !penable;
    // Unmapped addresses answer with an error and change nothing
    assign hit     = is_ctrl(paddr);
    // Zero wait states: a write lands at the single access edge
    assign wr_ctrl = psel && penable && pready && pwrite && hit;

    // Prescaler restarts on refresh; runs only outside halt and wake delay
    assign tk.restart = wr_ctrl;
    assign tk.run     = act_reg && (mode_reg == wdt_pkg::WDT_RUN);

    wdt_prescaler u_pre (
        .pclk    (pclk),
        .presetn (presetn),
        .tk      (tk)
    );

    // Count step only while active and running; a refresh on the same edge wins,
    // dropping that tick, which is harmless as the refresh restarts the step
    assign step         = tk.tick && act_reg && !wr_ctrl
                          && (mode_reg == wdt_pkg::WDT_RUN);
    // Natural expiry is the step that takes the count from 40h to 3Fh
    assign natural_trip = step && (count_reg == CNT_TRIP);
    // Forced expiry: a write that leaves the count msb clear while activated
    assign forced_trip  = wr_ctrl && asks_reset(pwdata[`WDT_ACT_BIT:0], act_reg);
    assign expire       = natural_trip || forced_trip;

    // ------------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------------
    // Activation is sticky; only reset clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_reg <= CTRL_RST[`WDT_ACT_BIT];
        end else if (wr_ctrl && pwdata[`WDT_ACT_BIT]) begin
            act_reg <= 1'b1;
        end
    end

    // Count loads on write, steps on each tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= CTRL_RST[`WDT_MSB_BIT:0];
        end else if (wr_ctrl) begin
            count_reg <= pwdata[`WDT_MSB_BIT:0];
        end else if (step) begin
            count_reg <= count_reg - 7'h01;
        end
    end

    // ------------------------------------------------------------------------
    // Halt and wake sequencing
    // ------------------------------------------------------------------------
    // Mode sequencing; a wake waits out the delay before counting again,
    // which keeps a freshly woken system from tripping at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= wdt_pkg::WDT_RUN;
        end else begin
            unique case (mode_reg)
                wdt_pkg::WDT_RUN: begin
                    if (halt_req) begin
                        mode_reg <= wdt_pkg::WDT_HALT;
                    end
                end
                wdt_pkg::WDT_HALT: begin
                    if (ext_wake) begin
                        mode_reg <= wdt_pkg::WDT_WAKE;
                    end
                end
                wdt_pkg::WDT_WAKE: begin
                    if (wake_done) begin
                        mode_reg <= wdt_pkg::WDT_RUN;
                    end
                end
                default: begin
                    mode_reg <= wdt_pkg::WDT_RUN;
                end
            endcase
        end
    end

    // Wake delay counter; held at zero elsewhere so each wake starts fresh
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_reg <= 13'h0000;
        end else if (mode_reg == wdt_pkg::WDT_WAKE && !wake_done) begin
            wake_reg <= wake_reg + 13'h0001;
        end else begin
            wake_reg <= 13'h0000;
        end
    end

    // Last cycle of the wake delay
    assign wake_done = (wake_reg == WAKE - 13'h0001);

    // ------------------------------------------------------------------------
    // Reset pulse
    // ------------------------------------------------------------------------
    // Fixed-length low pulse; a new expiry during a pulse is absorbed, except in its last low cycle, where it starts a new pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_reg   <= 8'h00;
            reset_n_out <= 1'b1;
        end else if (expire && pulse_reg == 8'h00) begin
            pulse_reg   <= PULSE - 8'h01;
            reset_n_out <= 1'b0;
        end else if (pulse_reg != 8'h00) begin
            pulse_reg   <= pulse_reg - 8'h01;
            reset_n_out <= 1'b0;
        end else begin
            reset_n_out <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // APB outputs
    // ------------------------------------------------------------------------
    // Ready answers every setup cycle one clock later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // Error flag for any address other than the control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup && !hit;
        end
    end

    // Read shows activation and live count; latched at setup so it
    // stands through the whole access cycle, zero otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup && !pwrite && hit) begin
            prdata <= ctrl_word(act_reg, count_reg);
        end else begin
            prdata <= 32'h00000000;
        end
    end
endmodule

/* File: sim/wdt_chk_props.sv */
// Assertion checker for the watchdog top ports
`timescale 1ns/10ps
module wdt_chk (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Reset request
    input wire logic        reset_n_out
);
    logic       map_ok;
    logic       act_q;
    logic [5:0] low_cnt;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed access to the control register
    assign map_ok = pready && paddr == 12'h00C;
    // Shadow of the activation bit, only reset clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) act_q <= 1'b0;
        else if (map_ok && pwrite && pwdata[7]) act_q <= 1'b1;
    end
    // Length of the running low pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) low_cnt <= 6'h00;
        else low_cnt <= reset_n_out ? 6'h00 : low_cnt + 6'h01;
    end
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    chk_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    chk_err_unmapped: assert property (pready |-> pslverr == (paddr != 12'h00C))
        else $error("pslverr wrong for address");
    chk_idle_rdata: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero when idle");
    chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_act_readback: assert property (map_ok && !pwrite |-> prdata[7] == act_q)
        else $error("activation bit readback wrong");
    chk_soft_reset: assert property (map_ok && pwrite && pwdata[7] && !pwdata[6]
        |-> ##[1:2] !reset_n_out)
        else $error("forced reset missing");
    chk_pulse_width: assert property ($rose(reset_n_out) |-> low_cnt == 6'h19)
        else $error("reset pulse length wrong");
    cov_unmapped: cover property (pready && pslverr);
    cov_write: cover property (map_ok && pwrite);
    cov_pulse: cover property ($fell(reset_n_out));
endmodule
bind wdt_top wdt_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_n_out(reset_n_out));

/* File: sim/tb.sv */
// Self-checking bench for the watchdog top
`timescale 1ns/10ps
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, reset_n_out, er;
    logic        halt_req, ext_wake;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          err_total, tests_run, n;
    wdt_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .halt_req(halt_req), .ext_wake(ext_wake), .reset_n_out(reset_n_out));
    // 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("Error %s exp %h got %h", nm, e, s);
        end
    endtask
    // One APB transfer; only the watchdog ends a wait on pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Edges until the reset request is seen low
    task automatic wait_low(input int lim);
        for (n = 0; reset_n_out !== 1'b0 && n < lim; n++) @(posedge pclk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Hang guard, run needs about 74k cycles
    initial begin
        #(100000 * 20);
        err_total++;
        report_and_stop();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, err_total, tests_run} = '0;
        {halt_req, ext_wake} = 2'b00;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h00C, 32'h0);
        chk("reset value", rd, 32'h7F);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", 32'(er), 32'h1);
        apb(1'b1, 12'h00C, 32'h40);
        apb(1'b0, 12'h00C, 32'h0);
        chk("inactive load", rd, 32'h40);
        apb(1'b1, 12'h00C, 32'hC0);
        apb(1'b1, 12'h00C, 32'h41);
        repeat (20000) @(posedge pclk);
        apb(1'b0, 12'h00C, 32'h0);
        chk("sticky act", rd, 32'hC1);
        // Refresh late, then halt at once; a prescaler not restarted steps too soon
        apb(1'b1, 12'h00C, 32'hC0);
        halt_req <= 1'b1;
        @(posedge pclk);
        halt_req <= 1'b0;
        repeat (300) @(posedge pclk);
        ext_wake <= 1'b1;
        @(posedge pclk);
        ext_wake <= 1'b0;
        // One full step plus the 4096-cycle wake delay; halt time does not count
        wait_low(60000);
        chk("expiry time", 32'(n >= 53248 && n <= 53254), 32'h1);
        for (n = 0; reset_n_out === 1'b0 && n < 100; n++) @(posedge pclk);
        chk("pulse len", 32'(n), 32'h19);
        apb(1'b0, 12'h00C, 32'h0);
        chk("expired count", rd, 32'hBF);
        apb(1'b1, 12'h00C, 32'hBF);
        wait_low(10);
        chk("forced reset", 32'(n <= 3), 32'h1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h00C, 32'h0);
        chk("second reset", rd, 32'h7F);
        report_and_stop();
    end
endmodule
